// File: core/ufc_pkg.sv
/*
 * Package of the FIFO control block: register offsets, field positions,
 * reset values and trigger codes.
 * Assumes a byte-addressed Avalon-MM slave with 32-bit words.
 */
package ufc_pkg;
    // Queue geometry
    localparam int UFC_DEPTH = 16;
    localparam int UFC_CHAR_W = 8;
    localparam int UFC_CNT_W = 5;

    // Register byte offsets
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_FIFO_CONTROL = 8'h08;
    localparam logic [7:0] OFF_INT_STATUS = 8'h0C;
    localparam logic [7:0] OFF_ALT_FUNC = 8'h10;
    localparam logic [7:0] OFF_LEVELS = 8'h14;
    localparam logic [7:0] OFF_EVT_STATUS = 8'h18;
    localparam logic [7:0] OFF_EVT_ENABLE = 8'h1C;
    localparam logic [7:0] OFF_EVT_CLEAR = 8'h20;

    // fifo_control field positions
    localparam int FC_ENABLE = 0;
    localparam int FC_RX_CLEAR = 1;
    localparam int FC_TX_CLEAR = 2;
    localparam int FC_DMA_MODE = 3;
    localparam int FC_THR_LO = 6;
    localparam int FC_THR_HI = 7;

    // interrupt_status_reg field positions
    localparam int IS_NO_PEND = 0;
    localparam int IS_EN_LO = 6;
    localparam int IS_EN_HI = 7;

    // alternate_function_reg field position
    localparam int AF_RX_READY_SEL = 0;

    // Event bit positions
    localparam int EV_RX = 0;
    localparam int EV_TX = 1;
    localparam int EV_OVERRUN = 2;
    localparam int EV_W = 3;

    // Reset values
    localparam logic RST_FIFO_EN = 1'b0;
    localparam logic RST_DMA_MODE = 1'b0;
    localparam logic [1:0] RST_THR = 2'h0;
    localparam logic RST_ALT_SEL = 1'b0;
    localparam logic [EV_W-1:0] RST_EVT = 3'h0;

    // Receive trigger levels by threshold code
    localparam logic [UFC_CNT_W-1:0] TRIG_00 = 5'h01;
    localparam logic [UFC_CNT_W-1:0] TRIG_01 = 5'h04;
    localparam logic [UFC_CNT_W-1:0] TRIG_10 = 5'h08;
    localparam logic [UFC_CNT_W-1:0] TRIG_11 = 5'h0E;
    // Capacity of the single holding register with queues off
    localparam logic [UFC_CNT_W-1:0] CAP_HOLD = 5'h01;
endpackage

// File: core/ufc_char_fifo.sv
/*
 * Character queue with occupancy counter and synchronous clear.
 * Assumes push and pop come from logic on the same clock.
 */
`timescale 1ns/100ps
module ufc_char_fifo
    import ufc_pkg::*;
#(
    parameter int W = UFC_CHAR_W,
    parameter int DEPTH = UFC_DEPTH,
    parameter int CW = UFC_CNT_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic clr,
    input wire logic [CW-1:0] cap,
    // Write side
    input wire logic push,
    input wire logic [W-1:0] wdata,
    // Read side
    input wire logic pop,
    output logic [W-1:0] rdata,
    // Occupancy
    output logic [CW-1:0] count,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt;
    logic [AW-1:0] rd_ptr_r, rd_ptr_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic do_push, do_pop;

    assign full = (cnt_r >= cap);
    assign empty = (cnt_r == '0);
    assign count = cnt_r;
    assign rdata = mem[rd_ptr_r];
    assign do_push = push & ~full & ~clr;
    assign do_pop = pop & ~empty & ~clr;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        cnt_nxt = cnt_r;
        if (clr) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            cnt_nxt = '0;
        end else begin
            if (do_push) begin
                wr_ptr_nxt = wr_ptr_r + AW'(1);
            end
            if (do_pop) begin
                rd_ptr_nxt = rd_ptr_r + AW'(1);
            end
            if (do_push && !do_pop) begin
                cnt_nxt = cnt_r + CW'(1);
            end else if (do_pop && !do_push) begin
                cnt_nxt = cnt_r - CW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wr_ptr_r] <= wdata;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_count_bound: assert property (cnt_r <= CW'(DEPTH))
        else $error("queue count above depth");
    a_clear_empties: assert property (clr |=> cnt_r == '0)
        else $error("queue not empty after clear");
endmodule

// File: core/ufc_fifo_ctrl.sv
/*
 * FIFO control of one UART channel: fifo_control register, transmit and
 * receive character queues, DMA ready outputs and event interrupts.
 * Assumes the transmitter and receiver run on CLK_SYS; the Avalon-MM
 * master holds each request until waitrequest is seen low.
 */
`timescale 1ns/100ps
// What this block does
// - Enable bit turns both queues on
// - Other fields written only with enable set
// - Transmit clear empties queue, self-clears
// - Receive clear empties queue, self-clears
// - Threshold code selects 1, 4, 8, 14
// - Mode 1: receive event at threshold, keep filling
// - Bit 3 selects single or block mode
// - Mode 0: transmit ready low when empty
// - Mode 0: receive ready low while holding
// - Mode 1: transmit ready high only full
// - Mode 1: receive ready low until emptied
// - Receive ready shown only when selected
// - Mode 1: transmit event on free space
// - Mode 0: events per character
// - Bits 5 and 4 read zero
// - Status top bits show queues enabled
module ufc_fifo_ctrl
    import ufc_pkg::*;
#(
    parameter int DEPTH = UFC_DEPTH
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // Avalon-MM register slave
    input wire logic [7:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Transmitter side
    output logic [7:0] TX_CHAR,
    output logic TX_CHAR_VALID,
    input wire logic TX_CHAR_TAKE,
    // Receiver side
    input wire logic [7:0] RX_CHAR,
    input wire logic RX_CHAR_WRITE,
    input wire logic RX_TIMEOUT,
    // DMA signalling
    output logic TX_DMA_READY_N,
    output logic MULTI_FUNCTION_OUTPUT,
    // Interrupt
    output logic IRQ
);
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    function automatic logic [UFC_CNT_W-1:0] trig(input logic [1:0] c);
        case (c)
            2'h0: return TRIG_00;
            2'h1: return TRIG_01;
            2'h2: return TRIG_10;
            default: return TRIG_11;
        endcase
    endfunction

    logic ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic fifo_en_r, fifo_en_nxt;
    logic mode_r, mode_nxt;
    logic [1:0] thr_r, thr_nxt;
    logic tx_clr_r, tx_clr_nxt;
    logic rx_clr_r, rx_clr_nxt;
    logic alt_sel_r, alt_sel_nxt;
    logic rx_hold_r, rx_hold_nxt;
    logic rx_cond_r, tx_space_r;
    logic [EV_W-1:0] evt_stat_r, evt_stat_nxt;
    logic [EV_W-1:0] evt_en_r, evt_en_nxt;
    logic [EV_W-1:0] evt;
    logic wr_go, rd_go, wr_fcr, wr_fcr_on;
    logic blk;
    logic [UFC_CNT_W-1:0] cap, rx_level, tx_cnt, rx_cnt;
    logic tx_full, tx_empty, rx_full, rx_empty;
    logic tx_push, rx_pop, tx_pop_ok, rx_push_ok;
    logic rx_cond, tx_space, rx_rdy_n;
    logic [7:0] rx_head;

    // One wait state: the answer comes on the second cycle of a request
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
    assign AVS_READDATA = rdata_r;
    assign wr_go = AVS_WRITE & ack_r & AVS_BYTEENABLE[0];
    assign rd_go = AVS_READ & ack_r;
    assign wr_fcr = wr_go & hit(AVS_ADDRESS, OFF_FIFO_CONTROL);
    assign wr_fcr_on = wr_fcr & AVS_WRITEDATA[FC_ENABLE];
    assign tx_push = wr_go & hit(AVS_ADDRESS, OFF_DATA);
    assign rx_pop = rd_go & hit(AVS_ADDRESS, OFF_DATA);

    assign blk = fifo_en_r & mode_r;
    // queues off act as one holding register
    assign cap = fifo_en_r ? UFC_CNT_W'(DEPTH) : CAP_HOLD;
    assign rx_level = fifo_en_r ? trig(thr_r) : TRIG_00;
    assign rx_cond = rx_cnt >= rx_level;
    assign tx_space = tx_cnt < cap;
    assign tx_pop_ok = TX_CHAR_TAKE & ~tx_empty & ~tx_clr_r;
    assign rx_push_ok = RX_CHAR_WRITE & ~rx_full & ~rx_clr_r;
    assign TX_CHAR_VALID = ~tx_empty;

    ufc_char_fifo #(.W(UFC_CHAR_W), .DEPTH(DEPTH), .CW(UFC_CNT_W)) u_tx (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .clr(tx_clr_r),
        .cap(cap),
        .push(tx_push),
        .wdata(AVS_WRITEDATA[7:0]),
        .pop(TX_CHAR_TAKE),
        .rdata(TX_CHAR),
        .count(tx_cnt),
        .full(tx_full),
        .empty(tx_empty)
    );

    ufc_char_fifo #(.W(UFC_CHAR_W), .DEPTH(DEPTH), .CW(UFC_CNT_W)) u_rx (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .clr(rx_clr_r),
        .cap(cap),
        .push(RX_CHAR_WRITE),
        .wdata(RX_CHAR),
        .pop(rx_pop),
        .rdata(rx_head),
        .count(rx_cnt),
        .full(rx_full),
        .empty(rx_empty)
    );

    // Bus slave and control fields
    always_comb begin
        ack_nxt = (AVS_READ | AVS_WRITE) & ~ack_r;
        rdata_nxt = rdata_r;
        fifo_en_nxt = fifo_en_r;
        mode_nxt = mode_r;
        thr_nxt = thr_r;
        alt_sel_nxt = alt_sel_r;
        evt_en_nxt = evt_en_r;
        tx_clr_nxt = 1'b0;
        rx_clr_nxt = 1'b0;
        if (wr_fcr) begin
            fifo_en_nxt = AVS_WRITEDATA[FC_ENABLE];
            // Switching the queues on or off starts both from empty
            if (AVS_WRITEDATA[FC_ENABLE] != fifo_en_r) begin
                tx_clr_nxt = 1'b1;
                rx_clr_nxt = 1'b1;
            end
        end
        if (wr_fcr_on) begin
            mode_nxt = AVS_WRITEDATA[FC_DMA_MODE];
            thr_nxt = AVS_WRITEDATA[FC_THR_HI:FC_THR_LO];
            if (AVS_WRITEDATA[FC_TX_CLEAR]) begin
                tx_clr_nxt = 1'b1;
            end
            if (AVS_WRITEDATA[FC_RX_CLEAR]) begin
                rx_clr_nxt = 1'b1;
            end
        end
        if (wr_go && hit(AVS_ADDRESS, OFF_ALT_FUNC)) begin
            alt_sel_nxt = AVS_WRITEDATA[AF_RX_READY_SEL];
        end
        if (wr_go && hit(AVS_ADDRESS, OFF_EVT_ENABLE)) begin
            evt_en_nxt = AVS_WRITEDATA[EV_W-1:0];
        end
        if (AVS_READ && !ack_r) begin
            rdata_nxt = 32'h0000_0000;
            case (AVS_ADDRESS)
                OFF_DATA: rdata_nxt[7:0] = rx_head;
                // bits 5 and 4 read zero
                OFF_FIFO_CONTROL: rdata_nxt[7:0] = {thr_r, 2'h0, mode_r,
                    tx_clr_r, rx_clr_r, fifo_en_r};
                OFF_INT_STATUS: begin
                    rdata_nxt[IS_EN_HI] = fifo_en_r;
                    rdata_nxt[IS_EN_LO] = fifo_en_r;
                    rdata_nxt[IS_NO_PEND] = ~IRQ;
                end
                OFF_ALT_FUNC: rdata_nxt[AF_RX_READY_SEL] = alt_sel_r;
                OFF_LEVELS: rdata_nxt[12:0] = {tx_cnt, 3'h0, rx_cnt};
                OFF_EVT_STATUS: rdata_nxt[EV_W-1:0] = evt_stat_r;
                OFF_EVT_ENABLE: rdata_nxt[EV_W-1:0] = evt_en_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            fifo_en_r <= RST_FIFO_EN;
            mode_r <= RST_DMA_MODE;
            thr_r <= RST_THR;
            tx_clr_r <= 1'b0;
            rx_clr_r <= 1'b0;
            alt_sel_r <= RST_ALT_SEL;
            evt_en_r <= RST_EVT;
        end else begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
            fifo_en_r <= fifo_en_nxt;
            mode_r <= mode_nxt;
            thr_r <= thr_nxt;
            tx_clr_r <= tx_clr_nxt;
            rx_clr_r <= rx_clr_nxt;
            alt_sel_r <= alt_sel_nxt;
            evt_en_r <= evt_en_nxt;
        end
    end

    // Events, ready outputs and interrupt
    always_comb begin
        evt = '0;
        if (blk) begin
            evt[EV_RX] = rx_cond & ~rx_cond_r;
            evt[EV_TX] = tx_space & ~tx_space_r;
        end else begin
            evt[EV_RX] = rx_push_ok;
            evt[EV_TX] = tx_pop_ok;
        end
        evt[EV_OVERRUN] = RX_CHAR_WRITE & rx_full & ~rx_clr_r;
        // Set wins over a clear in the same cycle
        evt_stat_nxt = evt_stat_r;
        if (wr_go && hit(AVS_ADDRESS, OFF_EVT_CLEAR)) begin
            evt_stat_nxt = evt_stat_r & ~AVS_WRITEDATA[EV_W-1:0];
        end
        evt_stat_nxt = evt_stat_nxt | evt;
        rx_hold_nxt = blk & (rx_cnt != '0)
            & (rx_hold_r | rx_cond | RX_TIMEOUT);
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            evt_stat_r <= RST_EVT;
            rx_hold_r <= 1'b0;
            rx_cond_r <= 1'b0;
            tx_space_r <= 1'b1;
        end else begin
            evt_stat_r <= evt_stat_nxt;
            rx_hold_r <= rx_hold_nxt;
            rx_cond_r <= rx_cond;
            tx_space_r <= tx_space;
        end
    end

    assign TX_DMA_READY_N = blk ? (tx_cnt == cap) : ~tx_empty;
    assign rx_rdy_n = blk ? ~rx_hold_r : rx_empty;
    assign MULTI_FUNCTION_OUTPUT = alt_sel_r ? rx_rdy_n : 1'b1;
    assign IRQ = |(evt_stat_r & evt_en_r);

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence s_blk_ready_low;
        blk && !rx_rdy_n && rx_cnt != '0;
    endsequence

    sequence s_blk_still_filled;
        blk && rx_cnt != '0;
    endsequence

    a_enable_bit_taken: assert property (
        wr_fcr |=> fifo_en_r == $past(AVS_WRITEDATA[FC_ENABLE]))
        else $error("enable bit not taken from write");
    a_fields_guarded: assert property (
        wr_fcr && !AVS_WRITEDATA[FC_ENABLE]
        |=> $stable(mode_r) && $stable(thr_r))
        else $error("fields changed without enable set");
    a_tx_clear_self: assert property (
        wr_fcr_on && AVS_WRITEDATA[FC_TX_CLEAR]
        |=> tx_clr_r ##1 !tx_clr_r && tx_cnt == '0)
        else $error("transmit clear did not empty or self-clear");
    a_rx_clear_self: assert property (
        wr_fcr_on && AVS_WRITEDATA[FC_RX_CLEAR]
        |=> rx_clr_r ##1 !rx_clr_r && rx_cnt == '0)
        else $error("receive clear did not empty or self-clear");
    a_threshold_code: assert property (
        fifo_en_r && thr_r == 2'h3 |-> rx_level == 5'h0E)
        else $error("threshold code 11 not fourteen");
    a_rx_event_level: assert property (
        blk && $rose(rx_cond) |-> rx_cnt == rx_level ##1 evt_stat_r[EV_RX])
        else $error("receive event not at trigger level");
    a_mode_select: assert property (
        wr_fcr_on |=> mode_r == $past(AVS_WRITEDATA[FC_DMA_MODE]))
        else $error("DMA mode not taken from bit 3");
    a_single_tx_ready: assert property (
        !blk && tx_push && !tx_full && !tx_clr_r |=> TX_DMA_READY_N)
        else $error("transmit ready not high after load");
    a_single_rx_ready: assert property (
        !blk && alt_sel_r |-> MULTI_FUNCTION_OUTPUT == (rx_cnt == '0))
        else $error("single mode receive ready wrong");
    a_block_tx_ready: assert property (
        blk |-> TX_DMA_READY_N == (tx_cnt == UFC_CNT_W'(DEPTH)))
        else $error("block mode transmit ready wrong");
    a_block_rx_hold: assert property (
        s_blk_ready_low ##1 s_blk_still_filled |-> !rx_rdy_n)
        else $error("receive ready released before empty");
    a_rx_ready_hidden: assert property (
        !alt_sel_r |-> MULTI_FUNCTION_OUTPUT)
        else $error("receive ready shown while not selected");
    a_block_tx_event: assert property (
        blk && tx_space && !tx_space_r |=> evt_stat_r[EV_TX])
        else $error("transmit space event missing");
    a_single_rx_event: assert property (
        !blk && rx_push_ok |=> evt_stat_r[EV_RX])
        else $error("per character receive event missing");
    a_unused_bits_zero: assert property (
        rd_go && hit(AVS_ADDRESS, OFF_FIFO_CONTROL)
        |-> AVS_READDATA[5:4] == 2'h0)
        else $error("fifo_control bits 5 and 4 not zero");
    a_status_enable: assert property (
        rd_go && hit(AVS_ADDRESS, OFF_INT_STATUS)
        |-> AVS_READDATA[7:6] == {2{$past(fifo_en_r)}})
        else $error("status top bits do not show enable");
    a_tx_clear_once: assert property (
        tx_clr_r |=> !tx_clr_r)
        else $error("transmit clear pulse longer than one cycle");
    a_rx_clear_once: assert property (
        rx_clr_r |=> !rx_clr_r)
        else $error("receive clear pulse longer than one cycle");
    a_block_rx_low: assert property (
        blk && rx_cnt != '0 && (rx_cond || RX_TIMEOUT) ##1 blk
        |-> !rx_rdy_n)
        else $error("receive ready not lowered at level or time-out");
    a_block_rx_release: assert property (
        blk && rx_cnt == '0 ##1 blk |-> rx_rdy_n)
        else $error("receive ready still low with queue empty");
endmodule

// File: sim/ufc_link_model.sv
/*
 * Far-side model: a receiver feeding characters and a transmitter that
 * drains the transmit queue on request.
 * Assumes the bench drives start, num and drain at the rising edge.
 */
`timescale 1ns/100ps
module ufc_link_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bench controls
    input wire logic start,
    input wire logic [4:0] num,
    input wire logic drain,
    // Transmitter link
    input wire logic [7:0] tx_char,
    input wire logic tx_valid,
    output logic tx_take,
    output logic [7:0] tx_last,
    // Receiver link
    output logic [7:0] rx_char,
    output logic rx_write
);
    logic [4:0] left_r;
    logic [7:0] ch_r;
    assign tx_take = drain & tx_valid;
    assign rx_write = (left_r != 5'h00);
    // Idle data line shows the inverse of the last character
    assign rx_char = rx_write ? ch_r : ~(ch_r - 8'h01);
    // pushes on past the level and past full
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            left_r <= 5'h00;
            ch_r <= 8'h30;
        end else if (start) begin
            left_r <= num;
        end else if (rx_write) begin
            left_r <= left_r - 5'h01;
            ch_r <= ch_r + 8'h01;
        end
    end
    always_ff @(posedge clk) begin
        if (tx_take) begin
            tx_last <= tx_char;
        end
    end
endmodule

// File: sim/ufc_fifo_ctrl_test.sv
/*
 * Self-checking bench of the FIFO control block over Avalon-MM.
 * Assumes one 125 MHz clock and the link model on the far side.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ufc_fifo_ctrl_test;
    import ufc_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] AVS_ADDRESS = 8'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [31:0] AVS_READDATA;
    logic AVS_WAITREQUEST;
    logic [7:0] TX_CHAR;
    logic TX_CHAR_VALID;
    logic TX_CHAR_TAKE;
    logic [7:0] RX_CHAR;
    logic RX_CHAR_WRITE;
    logic RX_TIMEOUT = 1'b0;
    logic TX_DMA_READY_N;
    logic MULTI_FUNCTION_OUTPUT;
    logic IRQ;
    logic start = 1'b0;
    logic [4:0] num = 5'h00;
    logic drain = 1'b0;
    logic [7:0] tx_last;
    logic [31:0] rd;
    int failures = 0;
    int checks = 0;
    int lvl[4] = '{1, 4, 8, 14};

    ufc_fifo_ctrl u_ufc_fifo_ctrl (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .TX_CHAR(TX_CHAR),
        .TX_CHAR_VALID(TX_CHAR_VALID), .TX_CHAR_TAKE(TX_CHAR_TAKE),
        .RX_CHAR(RX_CHAR), .RX_CHAR_WRITE(RX_CHAR_WRITE),
        .RX_TIMEOUT(RX_TIMEOUT), .TX_DMA_READY_N(TX_DMA_READY_N),
        .MULTI_FUNCTION_OUTPUT(MULTI_FUNCTION_OUTPUT), .IRQ(IRQ));
    ufc_link_model u_ufc_link_model (.clk(CLK_SYS), .rst_n(RST_N),
        .start(start), .num(num), .drain(drain), .tx_char(TX_CHAR),
        .tx_valid(TX_CHAR_VALID), .tx_take(TX_CHAR_TAKE),
        .tx_last(tx_last), .rx_char(RX_CHAR), .rx_write(RX_CHAR_WRITE));

    initial begin
        forever #4 CLK_SYS = ~CLK_SYS;
    end

    task automatic wrap_up;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic av_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= 1'b1;
        do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
        AVS_WRITE <= 1'b0;
    endtask

    task automatic av_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK_SYS);
        AVS_ADDRESS <= a;
        AVS_READ <= 1'b1;
        do @(posedge CLK_SYS); while (AVS_WAITREQUEST !== 1'b0);
        d = AVS_READDATA;
        AVS_READ <= 1'b0;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        av_rd(a, d);
        `CHK(d, e)
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
    endtask

    task automatic send(input int n);
        @(posedge CLK_SYS);
        start <= 1'b1;
        num <= n[4:0];
        @(posedge CLK_SYS);
        start <= 1'b0;
        settle(n + 2);
    endtask

    task automatic pop1;
        @(posedge CLK_SYS);
        drain <= 1'b1;
        @(posedge CLK_SYS);
        drain <= 1'b0;
        settle(2);
    endtask

    initial begin
        #200000;
        failures++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        settle(1);
        // Reset values and ignored fields
        chk_rd(OFF_FIFO_CONTROL, 32'h0);
        chk_rd(OFF_INT_STATUS, 32'h1);
        `CHK(TX_DMA_READY_N, 1'b0)
        `CHK(IRQ, 1'b0)
        av_wr(OFF_FIFO_CONTROL, 32'hC8);
        chk_rd(OFF_FIFO_CONTROL, 32'h0);
        chk_rd(8'h3C, 32'h0);
        // Single holding register, events, mask and clear
        av_wr(OFF_EVT_ENABLE, 32'h7);
        chk_rd(OFF_EVT_ENABLE, 32'h7);
        av_wr(OFF_DATA, 32'h55);
        settle(1);
        `CHK(TX_DMA_READY_N, 1'b1)
        `CHK(TX_CHAR_VALID, 1'b1)
        pop1();
        `CHK(tx_last, 8'h55)
        `CHK(TX_CHAR_VALID, 1'b0)
        `CHK(TX_DMA_READY_N, 1'b0)
        chk_rd(OFF_EVT_STATUS, 32'h2);
        `CHK(IRQ, 1'b1)
        av_wr(OFF_EVT_ENABLE, 32'h0);
        settle(1);
        `CHK(IRQ, 1'b0)
        av_wr(OFF_EVT_CLEAR, 32'h7);
        chk_rd(OFF_EVT_STATUS, 32'h0);
        av_wr(OFF_EVT_ENABLE, 32'h7);
        // Queues on, mode 0 receive
        av_wr(OFF_FIFO_CONTROL, 32'h1);
        chk_rd(OFF_INT_STATUS, 32'hC1);
        send(1);
        `CHK(MULTI_FUNCTION_OUTPUT, 1'b1)
        av_wr(OFF_ALT_FUNC, 32'h1);
        settle(1);
        `CHK(MULTI_FUNCTION_OUTPUT, 1'b0)
        chk_rd(OFF_EVT_STATUS, 32'h1);
        av_rd(OFF_DATA, rd);
        `CHK(rd[7:0], 8'h30)
        settle(1);
        `CHK(MULTI_FUNCTION_OUTPUT, 1'b1)
        // Mode 1 trigger levels, each code
        for (int i = 0; i < 4; i++) begin
            av_wr(OFF_FIFO_CONTROL, {24'h0, i[1:0], 6'h0B});
            av_wr(OFF_EVT_CLEAR, 32'h7);
            if (lvl[i] > 1) begin
                send(lvl[i] - 1);
            end
            av_rd(OFF_EVT_STATUS, rd);
            `CHK(rd[0], 1'b0)
            `CHK(MULTI_FUNCTION_OUTPUT, 1'b1)
            send(1);
            av_rd(OFF_EVT_STATUS, rd);
            `CHK(rd[0], 1'b1)
            `CHK(MULTI_FUNCTION_OUTPUT, 1'b0)
            chk_rd(OFF_FIFO_CONTROL, {24'h0, i[1:0], 6'h09});
        end
        send(2);
        av_rd(OFF_LEVELS, rd);
        `CHK(rd[4:0], 5'h10)
        send(1);
        av_rd(OFF_EVT_STATUS, rd);
        `CHK(rd[2], 1'b1)
        av_wr(OFF_FIFO_CONTROL, 32'hCB);
        settle(2);
        `CHK(MULTI_FUNCTION_OUTPUT, 1'b1)
        av_rd(OFF_LEVELS, rd);
        `CHK(rd[4:0], 5'h00)
        // Time-out below the level, ready held until emptied
        av_wr(OFF_FIFO_CONTROL, 32'h8B);
        send(2);
        `CHK(MULTI_FUNCTION_OUTPUT, 1'b1)
        @(posedge CLK_SYS);
        RX_TIMEOUT <= 1'b1;
        @(posedge CLK_SYS);
        RX_TIMEOUT <= 1'b0;
        settle(1);
        `CHK(MULTI_FUNCTION_OUTPUT, 1'b0)
        av_rd(OFF_DATA, rd);
        settle(1);
        `CHK(MULTI_FUNCTION_OUTPUT, 1'b0)
        av_rd(OFF_DATA, rd);
        settle(1);
        `CHK(MULTI_FUNCTION_OUTPUT, 1'b1)
        // Mode 1 transmit: fill to refusal, free one, clear
        av_wr(OFF_FIFO_CONTROL, 32'h8D);
        for (int j = 0; j < 15; j++) begin
            av_wr(OFF_DATA, j);
        end
        settle(1);
        `CHK(TX_DMA_READY_N, 1'b0)
        av_wr(OFF_DATA, 32'h0F);
        settle(1);
        `CHK(TX_DMA_READY_N, 1'b1)
        av_wr(OFF_DATA, 32'hAA);
        av_rd(OFF_LEVELS, rd);
        `CHK(rd[12:8], 5'h10)
        av_wr(OFF_EVT_CLEAR, 32'h7);
        pop1();
        `CHK(tx_last, 8'h00)
        `CHK(TX_DMA_READY_N, 1'b0)
        av_rd(OFF_EVT_STATUS, rd);
        `CHK(rd[1], 1'b1)
        av_wr(OFF_FIFO_CONTROL, 32'h8D);
        av_rd(OFF_LEVELS, rd);
        `CHK(rd[12:8], 5'h00)
        chk_rd(OFF_FIFO_CONTROL, 32'h89);
        av_wr(OFF_FIFO_CONTROL, 32'h0);
        av_rd(OFF_INT_STATUS, rd);
        `CHK(rd[7:6], 2'h0)
        // Reset in mid-run returns every field to its default
        @(posedge CLK_SYS);
        RST_N <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        settle(1);
        chk_rd(OFF_ALT_FUNC, 32'h0);
        chk_rd(OFF_EVT_ENABLE, 32'h0);
        chk_rd(OFF_INT_STATUS, 32'h1);
        chk_rd(OFF_FIFO_CONTROL, 32'h0);
        `CHK(MULTI_FUNCTION_OUTPUT, 1'b1)
        `CHK(TX_DMA_READY_N, 1'b0)
        `CHK(IRQ, 1'b0)
        wrap_up();
    end
endmodule
